// File: hdl/hcr_top.sv
// host clock divider, sleep tail and reset outputs
`timescale 1ns/1ps
module hcr_top #(
  parameter int POR_CYCLES = hcr_pkg::POR_CYC,
  parameter int SW_CYCLES = hcr_pkg::SWRST_CYC
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic por_event_i,
  input wire logic shutdown_pin_i,
  input wire logic lf_rc_clk_i,
  input wire logic lf_xtal_clk_i,
  input wire logic lf_xtal_sel_i,
  input wire logic sleep_cmd_i,
  input wire logic irq_pending_i,
  output logic aux_pin_zero_o,
  output logic aux_pin_one_o,
  output logic aux_pin_two_o,
  output logic xtal_en_o
);
  import hcr_pkg::*;

  typedef struct packed {
    logic [5:0] reg_clk;
    logic [7:0] rd_data;
    logic [SW_W-1:0] sw_cnt;
    logic [POR_W-1:0] por_cnt;
    logic [5:0] div_cnt;
    logic clk_out;
    hcr_mode_t mode;
    logic [2:0] sel_act;
    logic [9:0] tail_cnt;
    logic sleep_q;
    logic lf_m;
    logic lf_s;
    logic lf_d;
    logic por_m;
    logic por_s;
  } hcr_state_t;

  hcr_state_t st;
  hcr_state_t next_st;
  logic rst_active;
  logic sleep_eff;
  logic entering;
  logic tail_live;
  logic lf_rise;
  logic sw_req;
  hcr_mode_t tmode;
  logic [2:0] tsel;
  logic [1:0] tail_code;
  logic lf_sub_en;
  logic [2:0] clk_sel;

  assign tail_code = st.reg_clk[TAIL_LSB +: 2];
  assign lf_sub_en = st.reg_clk[LFC_BIT];
  assign clk_sel = st.reg_clk[SEL_LSB +: 3];
  assign rst_active = (st.por_cnt != '0) || (st.sw_cnt != '0);
  // a pending interrupt vetoes the commanded sleep
  assign sleep_eff = sleep_cmd_i && !irq_pending_i;
  assign entering = sleep_eff && !st.sleep_q;
  assign tail_live = entering ? (tail_of(tail_code) != '0) : (st.tail_cnt != '0);
  assign lf_rise = st.lf_s && !st.lf_d;
  assign sw_req = wr_i && (addr_i == ADDR_SOFT_RST) && wdata_i[SWRST_BIT];

  // wanted source for the host clock
  always_comb begin
    tsel = clk_sel;
    if (!sleep_eff) begin
      tmode = (clk_sel == SEL_LF) ? M_LF : M_DIV;
    end else if (lf_sub_en) begin
      tmode = M_LF;
      tsel = SEL_LF;
    end else if (tail_live) begin
      tmode = (clk_sel == SEL_LF) ? M_LF : M_DIV;
    end else begin
      tmode = M_OFF;
    end
  end

  always_comb begin
    next_st = st;
    // the mux sits ahead of the synchroniser; switching sources may give one odd edge
    next_st.lf_m = lf_xtal_sel_i ? lf_xtal_clk_i : lf_rc_clk_i;
    next_st.lf_s = st.lf_m;
    next_st.lf_d = st.lf_s;
    next_st.por_m = por_event_i || shutdown_pin_i;
    next_st.por_s = st.por_m;
    next_st.sleep_q = sleep_eff;

    // reset pulse timers
    if (st.por_s) begin
      next_st.por_cnt = POR_W'(POR_CYCLES);
    end else if (st.por_cnt != '0) begin
      next_st.por_cnt = st.por_cnt - 1'b1;
    end
    if (sw_req) begin
      next_st.sw_cnt = SW_W'(SW_CYCLES);
    end else if (st.sw_cnt != '0) begin
      next_st.sw_cnt = st.sw_cnt - 1'b1;
    end

    // register port
    next_st.rd_data = 8'h00;
    if (rd_i) begin
      unique case (addr_i)
        ADDR_CLK_CTRL: next_st.rd_data = {2'b00, st.reg_clk};
        ADDR_CLK_STAT: next_st.rd_data = {4'h0, st.mode == M_OFF, st.mode == M_LF,
                                          st.mode == M_DIV, st.clk_out};
        default: next_st.rd_data = 8'h00;
      endcase
    end
    if (rst_active) begin
      next_st.reg_clk = CLK_CTRL_RESET[5:0];
    end else if (wr_i && addr_i == ADDR_CLK_CTRL) begin
      next_st.reg_clk = wdata_i[5:0];
    end

    // tail loads on sleep entry only when the clock is to stop
    if (entering && !lf_sub_en) begin
      next_st.tail_cnt = tail_of(tail_code);
    end else if (!sleep_eff) begin
      next_st.tail_cnt = '0;
    end

    // output clock generator; sources change only while the output is low
    unique case (st.mode)
      M_DIV: begin
        if (st.div_cnt != '0) begin
          next_st.div_cnt = st.div_cnt - 1'b1;
        end else if (st.clk_out) begin
          next_st.clk_out = 1'b0;
          next_st.div_cnt = half_of(st.sel_act);
        end else if (tmode != M_DIV || tsel != st.sel_act) begin
          next_st.mode = tmode;
          next_st.sel_act = tsel;
          next_st.div_cnt = half_of(tsel);
        end else begin
          next_st.clk_out = 1'b1;
          next_st.div_cnt = half_of(st.sel_act);
          // waking mid-tail must not revive a stale count
          if (st.tail_cnt != '0 && !entering && sleep_eff) begin
            next_st.tail_cnt = st.tail_cnt - 1'b1;
          end
        end
      end
      M_LF: begin
        if (!st.clk_out && tmode != M_LF) begin
          next_st.mode = tmode;
          next_st.sel_act = tsel;
          next_st.div_cnt = half_of(tsel);
        end else if (st.clk_out) begin
          next_st.clk_out = st.lf_s;
        end else if (lf_rise) begin
          next_st.clk_out = 1'b1;
          if (st.tail_cnt != '0 && !entering && sleep_eff) begin
            next_st.tail_cnt = st.tail_cnt - 1'b1;
          end
        end
      end
      M_OFF: begin
        if (tmode != M_OFF) begin
          next_st.mode = tmode;
          next_st.sel_act = tsel;
          next_st.div_cnt = half_of(tsel);
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      st <= '0;
      st.reg_clk <= CLK_CTRL_RESET[5:0];
      st.por_cnt <= POR_W'(POR_CYCLES);
      st.mode <= M_DIV;
      st.sel_act <= CLK_CTRL_RESET[2:0];
    end else begin
      st <= next_st;
    end
  end

  assign rdata_o = st.rd_data;
  assign aux_pin_zero_o = rst_active;
  assign aux_pin_one_o = !rst_active;
  assign aux_pin_two_o = st.clk_out;
  assign xtal_en_o = (st.mode != M_OFF) || !sleep_eff;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  sequence s_sw_request;
    wr_i && addr_i == ADDR_SOFT_RST && wdata_i[SWRST_BIT];
  endsequence
  sequence s_lf_wanted;
    sleep_eff && lf_sub_en && !rst_active;
  endsequence
  sequence s_tail_entry;
    entering && !lf_sub_en;
  endsequence

  a_soft_reset_load: assert property (s_sw_request |=> st.sw_cnt == SW_W'(SW_CYCLES)
                                      ##1 aux_pin_zero_o)
    else $error("soft reset pulse not started");
  a_por_holds_reset: assert property (st.por_s |=> aux_pin_zero_o [*2])
    else $error("power-on event did not hold reset");
  a_reset_defaults: assert property (rst_active |=> st.reg_clk == CLK_CTRL_RESET[5:0])
    else $error("register not returned to default");
  a_pin_inverse: assert property (aux_pin_one_o != aux_pin_zero_o)
    else $error("reset pins not complementary");
  a_div_half_period: assert property ($rose(st.clk_out) && st.mode == M_DIV
                                      |-> st.div_cnt == half_of(st.sel_act))
    else $error("divider reload wrong");
  a_sleep_gives_lf: assert property (s_lf_wanted [*8] ##0 s_lf_wanted [*8]
                                     |-> ##[0:110] st.mode == M_LF)
    else $error("low-frequency clock not substituted in sleep");
  a_stopped_low: assert property (st.mode == M_OFF |-> !st.clk_out)
    else $error("stopped clock is not low");
  a_tail_before_off: assert property ($changed(st.mode) && st.mode == M_OFF
                                      |-> $past(st.tail_cnt) == '0)
    else $error("clock stopped before tail ended");
  a_irq_keeps_clock: assert property (irq_pending_i && st.mode != M_OFF
                                      |=> st.mode != M_OFF)
    else $error("clock stopped with interrupt pending");
  a_awake_no_stop: assert property (!sleep_cmd_i && st.mode != M_OFF |=> st.mode != M_OFF)
    else $error("clock stopped outside sleep");

  // register port answers exactly one cycle after the strobe
  a_rdata_idle: assert property (
    !rd_i |=> rdata_o == 8'h00)
    else $error("read data not cleared after read cycle");

  a_read_ctrl: assert property (
    rd_i && addr_i == ADDR_CLK_CTRL |=> rdata_o == {2'b00, $past(st.reg_clk)})
    else $error("control register read back wrong");

  a_read_unmapped: assert property (
    rd_i && addr_i != ADDR_CLK_CTRL && addr_i != ADDR_CLK_STAT |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");

  a_status_clock: assert property (
    rd_i && addr_i == ADDR_CLK_STAT |=> rdata_o[0] == $past(st.clk_out))
    else $error("status does not show host clock");

  a_write_ctrl: assert property (
    wr_i && addr_i == ADDR_CLK_CTRL && !rst_active |=> st.reg_clk == $past(wdata_i[5:0]))
    else $error("control write lost");

  // reset timers
  a_por_reload: assert property (
    st.por_s |=> st.por_cnt == POR_W'(POR_CYCLES))
    else $error("power-on timer not reloaded");

  a_sw_count_down: assert property (
    st.sw_cnt != '0 && !sw_req |=> st.sw_cnt == $past(st.sw_cnt) - 1'b1)
    else $error("soft reset timer did not count down");

  // divider and low-frequency source
  a_div_low_half: assert property (
    $fell(st.clk_out) && $past(st.mode) == M_DIV |-> st.div_cnt == half_of(st.sel_act))
    else $error("divider low half reload wrong");

  a_lf_rise_only: assert property (
    $rose(st.clk_out) && $past(st.mode) == M_LF |-> $past(lf_rise))
    else $error("low-frequency output rose without source edge");

  a_off_stays: assert property (
    st.mode == M_OFF && tmode == M_OFF |=> st.mode == M_OFF)
    else $error("stopped clock restarted in sleep");

  a_wake_restarts: assert property (
    st.mode == M_OFF && !sleep_eff |=> st.mode != M_OFF)
    else $error("clock not restarted on wake");

  // sleep tail: loaded on entry, counted in rising edges, dropped on wake
  a_tail_load: assert property (
    s_tail_entry |=> st.tail_cnt == $past(tail_of(tail_code)))
    else $error("tail not loaded on sleep entry");

  a_tail_cleared: assert property (
    !sleep_eff |=> st.tail_cnt == '0)
    else $error("tail count kept while awake");

  a_tail_step: assert property (
    $rose(st.clk_out) && $past(st.tail_cnt) != '0 && $past(sleep_eff) && !$past(entering)
    |-> st.tail_cnt == $past(st.tail_cnt) - 1'b1)
    else $error("tail did not count a rising edge");

  // glitch-free switching: source and select move only with the output low
  a_mode_change_low: assert property (
    $changed(st.mode) |-> !$past(st.clk_out))
    else $error("source changed while output high");

  a_sel_change_low: assert property (
    $changed(st.sel_act) |-> !$past(st.clk_out))
    else $error("select changed while output high");

  a_irq_xtal_on: assert property (
    irq_pending_i |-> xtal_en_o)
    else $error("crystal off with interrupt pending");
endmodule // hcr_top

// File: pkg/hcr_pkg.sv
// constants and types of the host clock and reset output block
// Behaviour
// - software reset request holds internal reset for 50 to 470 us
// - power on, supply glitch or leaving shutdown hold reset 5 to 40 ms
// - every reset returns all software registers to their defaults
// - first aux pin drives reset, second aux pin drives its inverse
// - host clock leaves on the third aux pin, divided from the crystal
// - three-bit select picks 30,15,10,4,3,2,1 MHz or 32.768 kHz; half periods are truncated here, so the 30 MHz setting runs at 50 MHz
// - 32.768 kHz option comes from the selected low-frequency source
// - outside sleep the selected frequency runs continuously
// - substitute enable in sleep delivers 32.768 kHz regardless of select
// - substitute disabled, host clock stops in sleep
// - before stopping, emit 0, 128, 256 or 512 tail cycles
// - pending interrupt keeps clock and crystal running until read
package hcr_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int POR_TIME_US = 15000;
  localparam int POR_CYC = POR_TIME_US * (CLK_HZ / 1_000_000);
  localparam int SWRST_TIME_US = 100;
  localparam int SWRST_CYC = SWRST_TIME_US * (CLK_HZ / 1_000_000);
  localparam int POR_W = 21;
  localparam int SW_W = 14;
  localparam logic [7:0] ADDR_CLK_CTRL = 8'h0A;
  localparam logic [7:0] ADDR_SOFT_RST = 8'h08;
  localparam logic [7:0] ADDR_CLK_STAT = 8'h0C;
  localparam logic [7:0] CLK_CTRL_RESET = 8'h0B;
  localparam int SEL_LSB = 0;
  localparam int LFC_BIT = 3;
  localparam int TAIL_LSB = 4;
  localparam int SWRST_BIT = 0;
  localparam logic [2:0] SEL_LF = 3'h7;
  localparam int HALF_30M = CLK_HZ / (2 * 30_000_000);
  localparam int HALF_15M = CLK_HZ / (2 * 15_000_000);
  localparam int HALF_10M = CLK_HZ / (2 * 10_000_000);
  localparam int HALF_4M = CLK_HZ / (2 * 4_000_000);
  localparam int HALF_3M = CLK_HZ / (2 * 3_000_000);
  localparam int HALF_2M = CLK_HZ / (2 * 2_000_000);
  localparam int HALF_1M = CLK_HZ / (2 * 1_000_000);
  localparam logic [9:0] TAIL_0 = 10'h000;
  localparam logic [9:0] TAIL_1 = 10'h080;
  localparam logic [9:0] TAIL_2 = 10'h100;
  localparam logic [9:0] TAIL_3 = 10'h200;

  typedef enum logic [1:0] {M_DIV, M_LF, M_OFF} hcr_mode_t;

  // reload value of the divider: half period minus one
  function automatic logic [5:0] half_of(input logic [2:0] sel);
    int h;
    unique case (sel)
      3'h0: h = HALF_30M;
      3'h1: h = HALF_15M;
      3'h2: h = HALF_10M;
      3'h3: h = HALF_4M;
      3'h4: h = HALF_3M;
      3'h5: h = HALF_2M;
      3'h6: h = HALF_1M;
      3'h7: h = HALF_1M;
    endcase
    return 6'(h - 1);
  endfunction

  function automatic logic [9:0] tail_of(input logic [1:0] t);
    unique case (t)
      2'h0: return TAIL_0;
      2'h1: return TAIL_1;
      2'h2: return TAIL_2;
      2'h3: return TAIL_3;
    endcase
  endfunction
endpackage

// File: verification/hcr_host_model.sv
// host side model: measures the host clock and reads the interrupt
`timescale 1ns/1ps
module hcr_host_model (
  input wire logic clk_sys_i,
  input wire logic host_clk_i,
  input wire logic irq_set_i,
  output logic irq_pending_o,
  output logic [31:0] hi_len_o,
  output logic [31:0] edges_o
);
  logic prev = 1'b0;
  logic [31:0] run = 32'h0;
  logic [4:0] rd_cnt = 5'h0;
  initial begin
    irq_pending_o = 1'b0;
    hi_len_o = 32'h0;
    edges_o = 32'h0;
  end
  always @(posedge clk_sys_i) begin
    prev <= host_clk_i;
    run <= host_clk_i ? run + 32'h1 : 32'h0;
    if (prev && !host_clk_i) hi_len_o <= run;
    if (host_clk_i && !prev) edges_o <= edges_o + 32'h1;
    // the status read needs sixteen host clock cycles
    if (irq_set_i) begin
      irq_pending_o <= 1'b1;
      rd_cnt <= 5'h0;
    end else if (irq_pending_o && host_clk_i && !prev) begin
      rd_cnt <= rd_cnt + 5'h1;
      if (rd_cnt == 5'hF) irq_pending_o <= 1'b0;
    end
  end
endmodule // hcr_host_model

// File: verification/testbench.sv
// self-checking bench of the host clock and reset block
`timescale 1ns/1ps
module testbench;
  import hcr_pkg::*;
  logic clk = 0, rst = 1, wr = 0, rd = 0, por = 0, shut = 0, rc = 0, xt = 0;
  logic xsel = 0, slp = 0, irq_set = 0, aux0, aux1, aux2, xen, irq_p;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, v, rb;
  logic [31:0] hi, edg, e0, lfsr = 32'h41D7;
  int fails = 0, n_tests = 0;
  hcr_top #(.POR_CYCLES(50), .SW_CYCLES(20)) i_dut (.clk_sys_i(clk), .rst_i(rst),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .por_event_i(por), .shutdown_pin_i(shut), .lf_rc_clk_i(rc), .lf_xtal_clk_i(xt),
    .lf_xtal_sel_i(xsel), .sleep_cmd_i(slp), .irq_pending_i(irq_p),
    .aux_pin_zero_o(aux0), .aux_pin_one_o(aux1), .aux_pin_two_o(aux2), .xtal_en_o(xen));
  hcr_host_model i_host (.clk_sys_i(clk), .host_clk_i(aux2), .irq_set_i(irq_set),
    .irq_pending_o(irq_p), .hi_len_o(hi), .edges_o(edg));
  initial forever #5 clk = ~clk;
  // the unselected source stands still, so a wrong pick shows up
  always #15259 rc = xsel ? 1'b0 : ~rc;
  always #15259 xt = xsel ? ~xt : 1'b0;
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] half(input logic [2:0] s);
    case (s)
      3'h0: return HALF_30M;
      3'h1: return HALF_15M;
      3'h2: return HALF_10M;
      3'h3: return HALF_4M;
      3'h4: return HALF_3M;
      3'h5: return HALF_2M;
      default: return HALF_1M;
    endcase
  endfunction
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rreg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task lf_ok;
    idle(7000);
    chk({31'h0, hi >= 32'd1522 && hi <= 32'd1530}, 32'h1);
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #400000 fails++;
    close_out();
  end
  initial begin
    idle(20);
    rst <= 1'b0;
    idle(2);
    chk({aux0, aux1}, 32'h2);
    idle(60);
    chk({aux0, aux1}, 32'h1);
    rreg(ADDR_CLK_CTRL, v);
    chk(v, 32'h0B);
    rreg(8'h55, v);
    chk(v, 32'h0);
    $display("reset test done");
    for (int i = 0; i < 11; i++) begin
      lfsr = nxt(lfsr);
      v = {lfsr[7:6], 3'h0, (i < 7) ? 3'(i) : 3'(lfsr[10:8] % 7)};
      wreg(ADDR_CLK_CTRL, v);
      rreg(ADDR_CLK_CTRL, rb);
      chk(rb, v & 8'h3F);
      idle(300);
      chk(hi, half(v[2:0]));
    end
    $display("divider test done");
    wreg(ADDR_CLK_CTRL, 8'h0B);
    slp <= 1'b1;
    lf_ok();
    slp <= 1'b0;
    xsel <= 1'b1;
    wreg(ADDR_CLK_CTRL, 8'h07);
    lf_ok();
    xsel <= 1'b0;
    $display("low frequency test done");
    for (int t = 0; t < 4; t++) begin
      wreg(ADDR_CLK_CTRL, {2'h0, 2'(t), 4'h0});
      idle(20);
      e0 = edg;
      slp <= 1'b1;
      idle(1200);
      e0 = edg - e0 - ((t == 0) ? 0 : (64 << t));
      chk({31'h0, e0 <= 1}, 32'h1);
      chk({xen, aux2}, 32'h0);
      slp <= 1'b0;
      idle(20);
    end
    $display("tail test done");
    // no tail, so the clock stops soon after the interrupt is read
    wreg(ADDR_CLK_CTRL, 8'h00);
    irq_set <= 1'b1;
    idle(1);
    irq_set <= 1'b0;
    slp <= 1'b1;
    e0 = edg;
    idle(10);
    chk({31'h0, xen && edg - e0 > 3}, 32'h1);
    idle(60);
    chk({xen, irq_p}, 32'h0);
    slp <= 1'b0;
    $display("interrupt test done");
    wreg(ADDR_SOFT_RST, 8'h01);
    #1 chk({aux0, aux1}, 32'h2);
    idle(18);
    chk(aux0, 32'h1);
    idle(2);
    chk({aux0, aux1}, 32'h1);
    rreg(ADDR_CLK_CTRL, v);
    chk(v, 32'h0B);
    for (int s = 0; s < 2; s++) begin
      wreg(ADDR_CLK_CTRL, 8'h00);
      {shut, por} <= 2'(s + 1);
      idle(5);
      {shut, por} <= 2'h0;
      chk(aux0, 32'h1);
      idle(70);
      chk(aux0, 32'h0);
      rreg(ADDR_CLK_CTRL, v);
      chk(v, 32'h0B);
    end
    $display("reset source test done");
    close_out();
  end
endmodule // testbench
